// ---- inc/cdr_pkg.sv ----
// Package for the system control coprocessor debug, override and remap register bank.
// Assumes a single core clock domain; all users import the whole package.
package cdr_pkg;

   // Coprocessor access fields: primary register, secondary register, selector
   localparam logic [3:0] CDR_CRN_CONTEXT = 4'hd;
   localparam logic [3:0] CDR_CRN_RESERVED = 4'he;
   localparam logic [3:0] CDR_CRN_DEBUG   = 4'hf;
   localparam logic [2:0] CDR_OP1_MAIN    = 3'h0;
   localparam logic [3:0] CDR_CRM_C0      = 4'h0;
   localparam logic [3:0] CDR_CRM_C1      = 4'h1;
   localparam logic [3:0] CDR_CRM_C2      = 4'h2;
   localparam logic [2:0] CDR_SEL_0       = 3'h0;
   localparam logic [2:0] CDR_SEL_1       = 3'h1;
   localparam logic [2:0] CDR_SEL_2       = 3'h2;

   // Debug override bit positions
   localparam int CDR_DBG_ABT_DSIDE = 18;
   localparam int CDR_DBG_ABT_ISIDE = 17;
   localparam int CDR_DBG_NO_UCPF   = 16;
   localparam int CDR_DBG_FSU   = 14;
   localparam int CDR_DBG_UDWT  = 13;
   localparam int CDR_DBG_PWB   = 12;
   localparam int CDR_DBG_IMPREC = 11;
   localparam logic [31:0] CDR_DBG_MASK  = 32'h0007_7800;
   localparam logic [31:0] CDR_DBG_RESET = 32'h0000_1800;

   // Prefetch override bit positions
   localparam int CDR_PFU_BRPRED = 1;
   localparam int CDR_PFU_RETSTK = 0;
   localparam logic [31:0] CDR_PFU_MASK  = 32'h0000_0003;
   localparam logic [31:0] CDR_PFU_RESET = 32'h0000_0003;

   // Remap field layout: class code c sits at IS_BASE + 2c and DS_BASE + 2c
   localparam int CDR_RMP_IS_BASE = 8;
   localparam int CDR_RMP_DS_BASE = 0;
   localparam logic [31:0] CDR_RMP_MASK  = 32'h0000_ffff;
   localparam logic [31:0] CDR_RMP_RESET = 32'h0000_e4e4;

   // Undefined-reset registers still get a defined value in this design
   localparam logic [31:0] CDR_CTX_RESET = 32'h0000_0000;
   localparam logic [31:0] CDR_TST_RESET = 32'h0000_0000;

   // Attribute classes as held in each two-bit remap field
   typedef enum logic [1:0] {
      CDR_UNCACHED_UNBUFFERED = 2'h0,
      CDR_UNCACHED_BUFFERED   = 2'h1,
      CDR_WRITE_THROUGH_CLASS = 2'h2,
      CDR_WRITEBACK           = 2'h3
   } cdr_class_t;

   // One coprocessor register transfer from the core
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [2:0]  op1;
      logic [3:0]  crn;
      logic [3:0]  crm;
      logic [2:0]  sel;
      logic [31:0] wdata;
   } cdr_req_t;

   // Answer to a transfer, one cycle after it is taken
   typedef struct packed {
      logic        done;
      logic        undef;
      logic [31:0] rdata;
   } cdr_rsp_t;

   // Access stream from the core needing an attribute decision
   typedef struct packed {
      logic       valid;
      logic       iside;
      logic       store;
      logic       tlb_miss;
      logic       xlate_on;
      logic       dcache_on;
      cdr_class_t cls;
   } cdr_acc_t;

   // Decision returned for that access
   typedef struct packed {
      logic       valid;
      logic       abort;
      cdr_class_t cls;
   } cdr_att_t;

endpackage

// ---- hdl/cdr_decode.sv ----
// Decoder from a coprocessor transfer to a register select.
// Assumes a request struct from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cdr_decode
   import cdr_pkg::*;
(
   input  wire cdr_req_t req,
   output logic          sel_ctx,
   output logic          sel_dbg,
   output logic          sel_pfu,
   output logic          sel_tst,
   output logic          sel_rmp,
   output logic          sel_undef
);
   wire prim  = (req.op1 == CDR_OP1_MAIN);
   wire is_dbg = (req.crn == CDR_CRN_DEBUG) && prim;
   wire any_sel;

   assign sel_ctx = (req.crn == CDR_CRN_CONTEXT) && prim && (req.crm == CDR_CRM_C0)
                    && (req.sel == CDR_SEL_1);
   assign sel_dbg = is_dbg && (req.crm == CDR_CRM_C0) && (req.sel == CDR_SEL_0);
   assign sel_pfu = is_dbg && (req.crm == CDR_CRM_C0) && (req.sel == CDR_SEL_2);
   assign sel_tst = is_dbg && (req.crm == CDR_CRM_C1) && (req.sel == CDR_SEL_0);
   assign sel_rmp = is_dbg && (req.crm == CDR_CRM_C2) && (req.sel == CDR_SEL_0);
   assign any_sel = sel_ctx | sel_dbg | sel_pfu | sel_tst | sel_rmp;
   // Register 14 always traps; other encodings outside this bank trap too
   assign sel_undef = (req.crn == CDR_CRN_RESERVED) | ~any_sel;
endmodule
`default_nettype wire

// ---- hdl/cdr_remap.sv ----
// Remap of an attribute class through the remap register plus override bits.
// Assumes registered control values from the bank on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cdr_remap
   import cdr_pkg::*;
(
   input  wire cdr_acc_t    acc,
   input  wire logic [15:0] remap,
   input  wire logic        force_unbuf,
   input  wire logic        untrans_wt,
   output cdr_class_t       cls
);
   logic [1:0] is_fld [4];
   logic [1:0] ds_fld [4];
   cdr_class_t base;
   cdr_class_t mapped;

   for (genvar c = 0; c < 4; c++) begin : g_fld
      assign is_fld[c] = remap[CDR_RMP_IS_BASE + 2*c +: 2];
      assign ds_fld[c] = remap[CDR_RMP_DS_BASE + 2*c +: 2];
   end

   // Without translation, data side is write-through or uncached unbuffered
   assign base = (acc.xlate_on || acc.iside) ? acc.cls :
                 (acc.dcache_on && untrans_wt) ? CDR_WRITE_THROUGH_CLASS
                                               : CDR_UNCACHED_UNBUFFERED;
   assign mapped = cdr_class_t'(acc.iside ? is_fld[base] : ds_fld[base]);
   // Store override sits after remap so it wins over both
   assign cls = (!acc.iside && acc.store && force_unbuf
                 && mapped == CDR_UNCACHED_BUFFERED) ? CDR_UNCACHED_UNBUFFERED
                                                     : mapped;
endmodule
`default_nettype wire

// ---- hdl/cdr_bank.sv ----
// Register bank for context, debug override, prefetch override, test address, remap.
// Assumes coprocessor transfers and access attributes come from the core, same clock.
//
// Overview of operation
// - Context identifier at register 13, selector 1, read and write; resets zero.
// - Any access to register 14 raises undefined instruction, touching nothing.
// - Debug bit 18 set makes data TLB misses abort; resets zero.
// - Debug bit 17 set makes instruction TLB misses abort as data aborts.
// - Debug bit 16 set stops uncached instruction prefetch; resets zero.
// - Debug bit 14 forces uncached buffered stores unbuffered, beating remap.
// - Debug bit 13 makes untranslated data accesses write-through when dcache on.
// - Debug bit 12 enables pending write buffer; resets one.
// - Debug bit 11 enables imprecise aborts; resets one.
// - Prefetch bit 1 enables enhanced branch prediction; resets one.
// - Prefetch bit 0 enables the return stack; resets one.
// - Test address is 32-bit scratch, also selects TLB test entries.
// - Remap register replaces the attribute class from any source.
// - Instruction-side fields at [15:8], reset 11,10,01,00.
// - Data-side fields at [7:0], identity reset; [31:16] reserved.
// - Field codes: 00 unbuffered, 01 buffered, 10 write-through, 11 write-back.
// - All registers reachable with either translation unit selected.
// - Register 15 op 0: c0/0 debug, c0/2 prefetch, c1/0 test, c2/0 remap.
`timescale 1ns/1ps
`default_nettype none
module cdr_bank
   import cdr_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire cdr_req_t    req,
   input  wire logic        translation_unit_select,
   input  wire cdr_acc_t    acc,
   output cdr_rsp_t         rsp,
   output cdr_att_t         att,
   output logic             disable_uncached_ifetch_prefetch,
   output logic             pending_write_buffer_on,
   output logic             imprecise_abort_on,
   output logic             enhanced_branch_predict_on,
   output logic             return_stack_on,
   output logic [31:0]      test_entry_select
);
   logic [31:0] context_identifier_reg;
   logic [31:0] debug_behaviour_override_reg;
   logic [31:0] prefetch_prediction_override_reg;
   logic [31:0] test_entry_address_scratch_reg;
   logic [31:0] region_attribute_remap_reg;
   cdr_rsp_t    rsp_reg;
   cdr_att_t    att_reg;
   cdr_rsp_t    rsp_next;
   cdr_att_t    att_next;

   wire sel_ctx;
   wire sel_dbg;
   wire sel_pfu;
   wire sel_tst;
   wire sel_rmp;
   wire sel_undef;
   wire cdr_class_t remap_cls;

   cdr_decode u_decode (
      .req       (req),
      .sel_ctx   (sel_ctx),
      .sel_dbg   (sel_dbg),
      .sel_pfu   (sel_pfu),
      .sel_tst   (sel_tst),
      .sel_rmp   (sel_rmp),
      .sel_undef (sel_undef)
   );

   cdr_remap u_remap (
      .acc         (acc),
      .remap       (region_attribute_remap_reg[15:0]),
      .force_unbuf (debug_behaviour_override_reg[CDR_DBG_FSU]),
      .untrans_wt  (debug_behaviour_override_reg[CDR_DBG_UDWT]),
      .cls         (remap_cls)
   );

   // Unit select does not gate any register
   wire unit_any = translation_unit_select | ~translation_unit_select;
   wire wr_ok    = req.valid && req.write && !sel_undef && unit_any;
   wire wr_ctx   = wr_ok && sel_ctx;
   wire wr_dbg   = wr_ok && sel_dbg;
   wire wr_pfu   = wr_ok && sel_pfu;
   wire wr_tst   = wr_ok && sel_tst;
   wire wr_rmp   = wr_ok && sel_rmp;

   // Read multiplexer; undefined accesses read zero
   wire [31:0] rd_mux =
      sel_ctx ? context_identifier_reg :
      sel_dbg ? debug_behaviour_override_reg :
      sel_pfu ? prefetch_prediction_override_reg :
      sel_tst ? test_entry_address_scratch_reg :
      sel_rmp ? region_attribute_remap_reg : 32'h0000_0000;

   wire miss_abort = acc.tlb_miss &&
      ((!acc.iside && debug_behaviour_override_reg[CDR_DBG_ABT_DSIDE]) ||
       ( acc.iside && debug_behaviour_override_reg[CDR_DBG_ABT_ISIDE]));

   always_comb begin
      rsp_next.done  = req.valid;
      rsp_next.undef = req.valid && sel_undef;
      rsp_next.rdata = (req.valid && !req.write && !sel_undef) ? rd_mux : 32'h0000_0000;
      att_next.valid = acc.valid;
      att_next.abort = acc.valid && miss_abort;
      att_next.cls   = remap_cls;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         context_identifier_reg <= CDR_CTX_RESET;
      end else if (wr_ctx) begin
         context_identifier_reg <= req.wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         debug_behaviour_override_reg <= CDR_DBG_RESET;
      end else if (wr_dbg) begin
         debug_behaviour_override_reg <= req.wdata & CDR_DBG_MASK;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prefetch_prediction_override_reg <= CDR_PFU_RESET;
      end else if (wr_pfu) begin
         prefetch_prediction_override_reg <= req.wdata & CDR_PFU_MASK;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         test_entry_address_scratch_reg <= CDR_TST_RESET;
      end else if (wr_tst) begin
         test_entry_address_scratch_reg <= req.wdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         region_attribute_remap_reg <= CDR_RMP_RESET;
      end else if (wr_rmp) begin
         region_attribute_remap_reg <= req.wdata & CDR_RMP_MASK;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rsp_reg <= '0;
         att_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
         att_reg <= att_next;
      end
   end

   assign rsp = rsp_reg;
   assign att = att_reg;
   assign disable_uncached_ifetch_prefetch =
      debug_behaviour_override_reg[CDR_DBG_NO_UCPF];
   assign pending_write_buffer_on = debug_behaviour_override_reg[CDR_DBG_PWB];
   assign imprecise_abort_on      = debug_behaviour_override_reg[CDR_DBG_IMPREC];
   assign enhanced_branch_predict_on =
      prefetch_prediction_override_reg[CDR_PFU_BRPRED];
   assign return_stack_on = prefetch_prediction_override_reg[CDR_PFU_RETSTK];
   assign test_entry_select = test_entry_address_scratch_reg;
endmodule
`default_nettype wire

// ---- tb/cdr_bank_assertions.sv ----
// Concurrent checks on the coprocessor register bank ports.
// Assumes one core clock and the active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module cdr_bank_checker
   import cdr_pkg::*;
(
   input wire logic        clock,
   input wire logic        rst,
   input wire cdr_req_t    req,
   input wire logic        translation_unit_select,
   input wire cdr_acc_t    acc,
   input wire cdr_rsp_t    rsp,
   input wire cdr_att_t    att,
   input wire logic        disable_uncached_ifetch_prefetch,
   input wire logic        pending_write_buffer_on,
   input wire logic        imprecise_abort_on,
   input wire logic        enhanced_branch_predict_on,
   input wire logic        return_stack_on,
   input wire logic [31:0] test_entry_select
);
   wire t15   = req.valid & req.write & (req.crn == CDR_CRN_DEBUG) & (req.op1 == CDR_OP1_MAIN);
   wire w_dbg = t15 & (req.crm == CDR_CRM_C0) & (req.sel == CDR_SEL_0);
   wire w_sl1 = req.valid & (req.crn == CDR_CRN_DEBUG) & (req.op1 == CDR_OP1_MAIN)
                & (req.crm == CDR_CRM_C0) & (req.sel == CDR_SEL_1);
   wire w_tst = t15 & (req.crm == CDR_CRM_C1) & (req.sel == CDR_SEL_0);
   wire c14   = req.valid & (req.crn == CDR_CRN_RESERVED);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_req_done_next: assert property (req.valid |=> rsp.done)
      else $error("transfer not answered in the next cycle");
   a_idle_no_done: assert property (!req.valid |=> !rsp.done)
      else $error("answer without a transfer");
   a_reserved_traps: assert property (c14 |=> rsp.undef && rsp.rdata == 32'h0)
      else $error("register 14 access not trapped");
   a_trap_keeps_state: assert property (c14 |=> $stable(test_entry_select)
      && $stable(pending_write_buffer_on) && $stable(imprecise_abort_on))
      else $error("trapped access changed state");
   a_forbidden_write_trap: assert property (w_sl1 |=> rsp.undef)
      else $error("unmapped selector access not trapped");
   a_scratch_write_seen: assert property (w_tst |=> !rsp.undef
      && test_entry_select == $past(req.wdata))
      else $error("test address not updated");
   a_debug_levels: assert property (w_dbg |=> !rsp.undef
      && pending_write_buffer_on == $past(req.wdata[12])
      && imprecise_abort_on == $past(req.wdata[11])
      && disable_uncached_ifetch_prefetch == $past(req.wdata[16]))
      else $error("debug override levels wrong");
   a_att_next: assert property (acc.valid |=> att.valid)
      else $error("attribute decision missing");
   a_hit_no_abort: assert property (acc.valid && !acc.tlb_miss |=> !att.abort)
      else $error("abort without a TLB miss");
   cover property (acc.valid && acc.tlb_miss ##1 att.abort);
   cover property (c14 ##1 rsp.undef);
   cover property (w_dbg ##1 !pending_write_buffer_on);
endmodule
bind cdr_bank cdr_bank_checker i_chk (.clock(clock), .rst(rst), .req(req),
   .translation_unit_select(translation_unit_select), .acc(acc), .rsp(rsp), .att(att),
   .disable_uncached_ifetch_prefetch(disable_uncached_ifetch_prefetch),
   .pending_write_buffer_on(pending_write_buffer_on), .imprecise_abort_on(imprecise_abort_on),
   .enhanced_branch_predict_on(enhanced_branch_predict_on),
   .return_stack_on(return_stack_on), .test_entry_select(test_entry_select));
`default_nettype wire

// ---- tb/cp_debug_override_remap_regs_test.sv ----
// Self-checking bench for the coprocessor register bank.
// Assumes the bank alone; the bench plays the core on both ports.
`timescale 1ns/1ps
`default_nettype none
module cp_debug_override_remap_regs_test
   import cdr_pkg::*;
;
   logic        clock;
   logic        rst;
   logic        tus;
   cdr_req_t    req;
   cdr_acc_t    acc;
   cdr_rsp_t    rsp;
   cdr_att_t    att;
   logic        nopf;
   logic        pwb;
   logic        impr;
   logic        brp;
   logic        rts;
   logic [31:0] tes;
   int          errors = 0;
   int          tests_run = 0;

   cdr_bank i_dut (.clock(clock), .rst(rst), .req(req), .translation_unit_select(tus),
      .acc(acc), .rsp(rsp), .att(att), .disable_uncached_ifetch_prefetch(nopf),
      .pending_write_buffer_on(pwb), .imprecise_abort_on(impr),
      .enhanced_branch_predict_on(brp), .return_stack_on(rts), .test_entry_select(tes));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task summarize;
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // One transfer: held until the taking edge, answer checked in the next cycle
   task xfer(input logic w, input logic [3:0] n, input logic [3:0] m, input logic [2:0] s,
             input logic [31:0] d, input logic u, input logic [31:0] e);
      @(posedge clock);
      req <= '{1'b1, w, CDR_OP1_MAIN, n, m, s, d};
      @(posedge clock);
      req.valid <= 1'b0;
      #1;
      chk(rsp.done === 1'b1 && rsp.undef === u && rsp.rdata === e, "register transfer");
   endtask

   task wr(input logic [3:0] n, input logic [3:0] m, input logic [2:0] s, input logic [31:0] d);
      xfer(1'b1, n, m, s, d, 1'b0, 32'h0);
   endtask

   task rd(input logic [3:0] n, input logic [3:0] m, input logic [2:0] s, input logic [31:0] e);
      xfer(1'b0, n, m, s, 32'h0, 1'b0, e);
   endtask

   task access(input logic i, input logic st, input logic ms, input logic xl, input logic dc,
               input logic [1:0] c, input logic ea, input logic [1:0] ec);
      @(posedge clock);
      acc <= '{1'b1, i, st, ms, xl, dc, cdr_class_t'(c)};
      @(posedge clock);
      acc.valid <= 1'b0;
      #1;
      chk(att.valid === 1'b1 && att.abort === ea && att.cls === ec, "attribute decision");
   endtask

   initial begin
      rst = 1'b1;
      tus = 1'b1;
      req = '0;
      acc = '0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk(pwb === 1'b1 && impr === 1'b1 && nopf === 1'b0, "debug reset levels");
      // Prefetch override is never written: prediction is on from reset
      chk(brp === 1'b1 && rts === 1'b1, "prefetch reset levels");
      rd(4'hf, 4'h0, 3'h0, 32'h0000_1800);
      rd(4'hf, 4'h0, 3'h2, 32'h0000_0003);
      rd(4'hf, 4'h2, 3'h0, 32'h0000_e4e4);
      for (int k = 0; k < 2; k++) begin
         tus <= k[0];
         wr(4'hd, 4'h0, 3'h1, 32'ha5a5_5a5a ^ k);
         rd(4'hd, 4'h0, 3'h1, 32'ha5a5_5a5a ^ k);
         wr(4'hf, 4'h1, 3'h0, 32'hffff_0001 ^ k);
         rd(4'hf, 4'h1, 3'h0, 32'hffff_0001 ^ k);
      end
      chk(tes === 32'hffff_0000, "test entry select");
      wr(4'hf, 4'h0, 3'h0, 32'hffff_ffff);
      rd(4'hf, 4'h0, 3'h0, 32'h0007_7800);
      chk(nopf === 1'b1, "uncached prefetch off");
      wr(4'hf, 4'h2, 3'h0, 32'hffff_ffff);
      rd(4'hf, 4'h2, 3'h0, 32'h0000_ffff);
      xfer(1'b0, 4'he, 4'h0, 3'h0, 32'h0, 1'b1, 32'h0);
      xfer(1'b1, 4'he, 4'h1, 3'h0, 32'h1234_5678, 1'b1, 32'h0);
      // Selector 1 of c0 is unmapped: a read of it traps as undefined
      xfer(1'b0, 4'hf, 4'h0, 3'h1, 32'h0, 1'b1, 32'h0);
      rd(4'hf, 4'h1, 3'h0, 32'hffff_0000);
      // Data side reversed, instruction side identity
      wr(4'hf, 4'h2, 3'h0, 32'h0000_e41b);
      for (int c = 0; c < 4; c++) begin
         access(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, c[1:0], 1'b0, ~c[1:0]);
         access(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, c[1:0], 1'b0, c[1:0]);
      end
      wr(4'hf, 4'h0, 3'h0, 32'h0004_1800);
      access(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h3, 1'b1, 2'h0);
      access(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'h3, 1'b0, 2'h3);
      wr(4'hf, 4'h0, 3'h0, 32'h0002_1800);
      access(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'h3, 1'b1, 2'h3);
      access(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h3, 1'b0, 2'h0);
      wr(4'hf, 4'h2, 3'h0, 32'h0000_e4e4);
      wr(4'hf, 4'h0, 3'h0, 32'h0000_5800);
      access(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h1, 1'b0, 2'h0);
      access(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 2'h1, 1'b0, 2'h1);
      wr(4'hf, 4'h0, 3'h0, 32'h0000_3800);
      access(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3, 1'b0, 2'h2);
      wr(4'hf, 4'h0, 3'h0, 32'h0000_0000);
      access(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3, 1'b0, 2'h0);
      chk(pwb === 1'b0 && impr === 1'b0, "buffer and imprecise off");
      summarize;
   end

   initial begin
      #100000;
      errors++;
      summarize;
   end
endmodule
`default_nettype wire
